// ==== design/smc_top.sv ====
// Purpose: sleep mode sequencing, clock domain gating and brown-out detector control
// Assumes: core pulses sleep_instr one cycle per executed sleep instruction
// Notes: wake inputs arrive already masked by their own interrupt enables
`timescale 1ns/1ps
module smc_top #(
    parameter int STARTUP_CYCLES = smc_pkg::STARTUP_CYC,
    parameter int BOD_WAKE_CYCLES = smc_pkg::BOD_WAKE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_instr,
    input wire smc_pkg::smc_wake_t wake_req,
    input wire smc_pkg::smc_periph_t periph,
    output smc_pkg::smc_clk_t clk_en,
    output logic [7:0] periph_clk_en,
    output logic [7:0] periph_access_en,
    output logic timer2_clk_en,
    output logic wdt_clk_en,
    output logic bod_enable,
    output logic adc_start,
    output logic adc_extended_next,
    output logic comparator_disable,
    output logic input_buf_off,
    output logic core_run
);
    import smc_pkg::*;

    localparam logic [15:0] STARTUP_W = 16'(STARTUP_CYCLES);
    localparam logic [15:0] BOD_WAKE_W = 16'(BOD_WAKE_CYCLES);
    localparam logic [15:0] STANDBY_W = 16'(STANDBY_WAKE_CYC);
    localparam logic [15:0] HALT_W = 16'(HALT_CYC);
    localparam logic [2:0] UNLOCK_W = 3'(UNLOCK_CYC);
    localparam logic [2:0] DOFF_ON_W = 3'(DOFF_DELAY_CYC);
    localparam logic [2:0] DOFF_END_W = 3'(DOFF_DELAY_CYC + DOFF_HOLD_CYC);

    logic sleep_enable_q, detector_off_unlock_q, detector_off_in_sleep_q;
    logic [2:0] sleep_kind_select_q, config_q, unlock_cnt_q, doff_age_q;
    logic [7:0] power_reduction_bits_q, rdata_q;
    smc_state_t state_q;
    smc_kind_t kind_q;
    logic bod_off_q, adc_start_q, adc_en_prev_q, adc_ext_q, ack_q;
    logic [15:0] wait_q, wake_delay;
    logic bus_req, wr_req, wr_sleep, wr_core, wr_power, wr_config, doff_active;
    logic kind_valid, enter_sleep, deep_kind, wake_hit, xtal_sel, sleeping;
    logic [7:0] wbyte, status_byte;
    smc_kind_t sel_kind;
    smc_clk_t gate;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_req = bus_req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign wr_sleep = wr_req & (wb_adr_i == ADDR_SLEEP_CTRL);
    assign wr_core = wr_req & (wb_adr_i == ADDR_CORE_CTRL);
    assign wr_power = wr_req & (wb_adr_i == ADDR_POWER_RED);
    assign wr_config = wr_req & (wb_adr_i == ADDR_CONFIG);
    assign xtal_sel = config_q[CFG_XTAL_BIT];
    assign sel_kind = smc_kind_t'(sleep_kind_select_q);
    assign sleeping = (state_q != ST_ACTIVE);

    // wishbone slave: one wait state, unmapped addresses ack with zero data
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    assign status_byte = {1'b0, kind_q, doff_active, bod_off_q, state_q};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (bus_req) begin
            case (wb_adr_i)
                ADDR_SLEEP_CTRL: rdata_q <= {4'h0, sleep_kind_select_q, sleep_enable_q};
                ADDR_CORE_CTRL: rdata_q <= {1'b0, detector_off_in_sleep_q,
                                            detector_off_unlock_q, 5'h00};
                ADDR_POWER_RED: rdata_q <= power_reduction_bits_q;
                ADDR_STATUS: rdata_q <= status_byte;
                ADDR_CONFIG: rdata_q <= {5'h00, config_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign wb_dat_o = {24'h000000, rdata_q};
    assign wb_ack_o = ack_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sleep_enable_q <= RST_SLEEP_CTRL[SE_BIT];
            sleep_kind_select_q <= RST_SLEEP_CTRL[KIND_LSB +: 3];
        end else if (wr_sleep) begin
            sleep_enable_q <= wbyte[SE_BIT];
            sleep_kind_select_q <= wbyte[KIND_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            power_reduction_bits_q <= RST_POWER_RED;
        end else if (wr_power) begin
            power_reduction_bits_q <= wbyte & PRR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            config_q <= RST_CONFIG;
        end else if (wr_config) begin
            config_q <= wbyte[2:0];
        end
    end

    // unlock window: opened by writing both bits to one, closes after four cycles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            detector_off_unlock_q <= 1'b0;
            unlock_cnt_q <= 3'd0;
        end else if (wr_core && wbyte[DOFF_BIT] && wbyte[UNLK_BIT]) begin
            detector_off_unlock_q <= 1'b1;
            unlock_cnt_q <= UNLOCK_W;
        end else if (unlock_cnt_q > 3'd1) begin
            unlock_cnt_q <= unlock_cnt_q - 3'd1;
        end else begin
            detector_off_unlock_q <= 1'b0;
            unlock_cnt_q <= 3'd0;
        end
    end

    // detector-off bit: set only inside the window, live from age 3 to 5, then clears
    always_ff @(posedge clk) begin
        if (!rstn) begin
            detector_off_in_sleep_q <= 1'b0;
            doff_age_q <= 3'd0;
        end else if (wr_core && detector_off_unlock_q && wbyte[DOFF_BIT] && !wbyte[UNLK_BIT]) begin
            detector_off_in_sleep_q <= 1'b1;
            doff_age_q <= 3'd0;
        end else if (detector_off_in_sleep_q) begin
            if (doff_age_q == DOFF_END_W - 3'd1) begin
                detector_off_in_sleep_q <= 1'b0;
                doff_age_q <= 3'd0;
            end else begin
                doff_age_q <= doff_age_q + 3'd1;
            end
        end
    end

    assign doff_active = detector_off_in_sleep_q && (doff_age_q >= DOFF_ON_W);

    assign kind_valid = (sel_kind != SK_RSVD4) && (sel_kind != SK_RSVD5);
    assign enter_sleep = (state_q == ST_ACTIVE) && sleep_instr && sleep_enable_q
                         && kind_valid;
    assign deep_kind = (sel_kind != SK_IDLE) && (sel_kind != SK_ADC_NR);

    // wake source filter for the kind of sleep being held
    always_comb begin
        wake_hit = 1'b0;
        case (kind_q)
            SK_IDLE: begin
                wake_hit = |wake_req;
            end
            SK_ADC_NR: begin
                wake_hit = wake_req.adc_done | wake_req.wdt_irq | wake_req.twi_match
                         | (wake_req.timer2_irq & periph.timer2_async)
                         | wake_req.spm_ready | wake_req.ext_level | wake_req.pin_change;
            end
            SK_PDOWN, SK_STBY: begin
                wake_hit = wake_req.wdt_irq | wake_req.twi_match
                         | wake_req.ext_level | wake_req.pin_change;
            end
            SK_PSAVE, SK_XSTBY: begin
                wake_hit = wake_req.wdt_irq | wake_req.twi_match
                         | wake_req.ext_level | wake_req.pin_change
                         | (wake_req.timer2_irq & periph.timer2_enabled
                            & periph.global_irq_en);
            end
            default: begin
                wake_hit = 1'b0;
            end
        endcase
    end

    // resume delay: start-up in power-down/save, six cycles in standby kinds with crystal, four in idle kinds
    always_comb begin
        wake_delay = HALT_W;
        case (kind_q)
            SK_PDOWN, SK_PSAVE: begin
                wake_delay = STARTUP_W;
            end
            SK_STBY, SK_XSTBY: begin
                wake_delay = xtal_sel ? STANDBY_W : STARTUP_W;
            end
            default: begin
                wake_delay = HALT_W;
            end
        endcase
        if (bod_off_q && wake_delay < BOD_WAKE_W) begin
            wake_delay = BOD_WAKE_W;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_ACTIVE;
            kind_q <= SK_IDLE;
            wait_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (enter_sleep) begin
                        state_q <= ST_SLEEP;
                        kind_q <= sel_kind;
                    end
                end
                ST_SLEEP: begin
                    if (wake_hit) begin
                        state_q <= ST_WAKE;
                        wait_q <= wake_delay - 16'h0001;
                    end
                end
                ST_WAKE: begin
                    if (wait_q == 16'h0000) begin
                        state_q <= ST_ACTIVE;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_ACTIVE;
                end
            endcase
        end
    end

    // detector shut off only for kinds that allow it, and only if armed at the instruction
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bod_off_q <= 1'b0;
        end else if (enter_sleep) begin
            bod_off_q <= doff_active && deep_kind;
        end else if (state_q == ST_WAKE && wait_q == 16'h0000) begin
            bod_off_q <= 1'b0;
        end
    end

    assign bod_enable = config_q[CFG_BODEN_BIT] & ~(bod_off_q & (state_q == ST_SLEEP));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            adc_start_q <= 1'b0;
        end else begin
            adc_start_q <= enter_sleep && !deep_kind && periph.adc_enabled;
        end
    end

    assign adc_start = adc_start_q;

    // the converter is never forced off here; a power cycle flags an extended conversion
    always_ff @(posedge clk) begin
        if (!rstn) begin
            adc_en_prev_q <= 1'b0;
            adc_ext_q <= 1'b0;
        end else begin
            adc_en_prev_q <= periph.adc_enabled;
            if (adc_en_prev_q && !periph.adc_enabled) begin
                adc_ext_q <= 1'b1;
            end else if (adc_start_q) begin
                adc_ext_q <= 1'b0;
            end
        end
    end

    assign adc_extended_next = adc_ext_q;

    // clock domain gating per held sleep kind
    always_comb begin
        gate = '1;
        if (state_q == ST_SLEEP) begin
            gate = '0;
            case (kind_q)
                SK_IDLE: begin
                    gate.io = 1'b1;
                    gate.adc = 1'b1;
                    gate.asy = 1'b1;
                    gate.main_osc = 1'b1;
                    gate.timer_osc = periph.timer2_async;
                end
                SK_ADC_NR: begin
                    gate.adc = 1'b1;
                    gate.asy = periph.timer2_async;
                    gate.main_osc = 1'b1;
                    gate.timer_osc = periph.timer2_async;
                end
                SK_PDOWN: begin
                    gate = '0;
                end
                SK_PSAVE: begin
                    gate.asy = periph.timer2_enabled;
                    gate.timer_osc = periph.timer2_async;
                    gate.main_osc = periph.timer2_enabled & ~periph.timer2_async;
                end
                SK_STBY: begin
                    gate.main_osc = xtal_sel;
                end
                SK_XSTBY: begin
                    gate.asy = periph.timer2_enabled & periph.timer2_async;
                    gate.timer_osc = periph.timer2_async;
                    gate.main_osc = xtal_sel | (periph.timer2_enabled & ~periph.timer2_async);
                end
                default: begin
                    gate = '1;
                end
            endcase
        end else if (state_q == ST_WAKE) begin
            gate = '0;
            gate.main_osc = 1'b1;
            gate.timer_osc = periph.timer2_async;
            gate.asy = periph.timer2_enabled;
        end
        if (config_q[CFG_DEBUG_BIT]) begin
            gate.main_osc = 1'b1;
        end
    end

    assign clk_en = gate;
    assign core_run = ~sleeping;

    // timer 2 on its own oscillator ignores io gating; synchronous it runs with io, or with asy while the main oscillator runs
    assign timer2_clk_en = ~power_reduction_bits_q[PR_TIM2_BIT]
                         & (periph.timer2_async ? gate.asy
                            : (gate.io | (gate.main_osc & gate.asy)));

    // per-peripheral clocks: a set bit freezes the module and hides its registers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_periph
            if (gi == PR_ADC_BIT) begin : g_adc
                assign periph_clk_en[gi] = gate.adc & ~power_reduction_bits_q[gi];
            end else if (gi == PR_TIM2_BIT) begin : g_tim2
                assign periph_clk_en[gi] = timer2_clk_en;
            end else begin : g_io
                // in deep sleep io is already off, so the bit has no extra effect
                assign periph_clk_en[gi] = gate.io & ~power_reduction_bits_q[gi];
            end
            assign periph_access_en[gi] = ~power_reduction_bits_q[gi];
        end
    endgenerate

    assign wdt_clk_en = periph.wdt_enabled;
    assign comparator_disable = (state_q == ST_SLEEP) && kind_q != SK_IDLE
                              && kind_q != SK_ADC_NR && !periph.comparator_uses_ref;
    // wake-detecting pins keep their buffers in the port logic regardless of this level
    assign input_buf_off = (state_q == ST_SLEEP) && !gate.io && !gate.adc;
endmodule

// ==== inc/smc_pkg.sv ====
// Purpose: shared constants and types of the sleep and clock gating controller
// Assumes: 100 MHz system clock, 8-bit registers on a 32-bit classic Wishbone bus
// Notes: every register keeps its data in bits 7..0, upper bits read as zero
package smc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOD_WAKE_NS = 60000;
    localparam int BOD_WAKE_CYC = (BOD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CYC = 1000;
    localparam int STANDBY_WAKE_CYC = 6;
    localparam int HALT_CYC = 4;
    localparam int UNLOCK_CYC = 4;
    localparam int DOFF_DELAY_CYC = 3;
    localparam int DOFF_HOLD_CYC = 3;

    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_POWER_RED = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;

    localparam int SE_BIT = 0;
    localparam int KIND_LSB = 1;
    localparam int DOFF_BIT = 6;
    localparam int UNLK_BIT = 5;
    localparam int CFG_XTAL_BIT = 0;
    localparam int CFG_DEBUG_BIT = 1;
    localparam int CFG_BODEN_BIT = 2;
    localparam int PR_ADC_BIT = 0;
    localparam int PR_TIM2_BIT = 6;
    localparam logic [7:0] PRR_MASK = 8'hEF;

    localparam logic [3:0] RST_SLEEP_CTRL = 4'h0;
    localparam logic [7:0] RST_POWER_RED = 8'h00;
    localparam logic [2:0] RST_CONFIG = 3'h4;

    typedef enum logic [2:0] {
        SK_IDLE = 3'b000,
        SK_ADC_NR = 3'b001,
        SK_PDOWN = 3'b010,
        SK_PSAVE = 3'b011,
        SK_RSVD4 = 3'b100,
        SK_RSVD5 = 3'b101,
        SK_STBY = 3'b110,
        SK_XSTBY = 3'b111
    } smc_kind_t;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10
    } smc_state_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } smc_clk_t;

    typedef struct packed {
        logic adc_done;
        logic wdt_irq;
        logic twi_match;
        logic timer2_irq;
        logic spm_ready;
        logic ext_level;
        logic ext_edge;
        logic pin_change;
        logic other_irq;
    } smc_wake_t;

    typedef struct packed {
        logic adc_enabled;
        logic timer2_enabled;
        logic timer2_async;
        logic comparator_uses_ref;
        logic wdt_enabled;
        logic global_irq_en;
    } smc_periph_t;
endpackage

// ==== test/smc_checker.sv ====
// Purpose: port-level assertions for the sleep and clock gating controller
// Assumes: bound to every smc_top instance; detector fuse left enabled by the bench
// Notes: internal state is invisible here, so rules are tied to clock pattern changes
`timescale 1ns/1ps
module smc_checker #(
    parameter int STARTUP_CYCLES = 8,
    parameter int BOD_WAKE_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sleep_instr,
    input wire smc_pkg::smc_periph_t periph,
    input wire smc_pkg::smc_clk_t clk_en,
    input wire logic [7:0] periph_clk_en,
    input wire logic [7:0] periph_access_en,
    input wire logic wdt_clk_en,
    input wire logic bod_enable,
    input wire logic adc_start,
    input wire logic adc_extended_next,
    input wire logic comparator_disable,
    input wire logic input_buf_off,
    input wire logic core_run
);
    import smc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    run_clocks_a: assert property (core_run |-> clk_en == 7'h7F)
        else $error("clock gated while core runs");
    sleep_cause_a: assert property ($fell(core_run) |-> $past(sleep_instr))
        else $error("core halted without a sleep instruction");
    cpu_flash_a: assert property (!clk_en.cpu |-> !clk_en.flash && !core_run)
        else $error("cpu and flash clocks not stopped together");
    io_stop_a: assert property (!clk_en.io |-> !clk_en.cpu)
        else $error("io clock stopped while cpu clock runs");
    osc_off_a: assert property (!clk_en.main_osc |-> !clk_en.io && !clk_en.adc)
        else $error("generated clock runs with oscillator stopped");
    adc_kick_a: assert property (adc_start |-> $fell(core_run) && clk_en.adc)
        else $error("conversion start outside shallow sleep entry");
    adc_ext_a: assert property ($fell(periph.adc_enabled) |=> adc_extended_next)
        else $error("extended conversion not flagged");
    red_gate_a: assert property (((periph_clk_en & ~periph_access_en) & 8'hBF) == 8'h00)
        else $error("reduced peripheral still clocked");
    deep_periph_a: assert property (!clk_en.io |-> (periph_clk_en & 8'hBE) == 8'h00)
        else $error("peripheral clock runs in deep sleep");
    buf_keep_a: assert property (clk_en.io || clk_en.adc |-> !input_buf_off)
        else $error("input buffers off with io or adc clock running");
    cmp_keep_a: assert property (clk_en.adc |-> !comparator_disable)
        else $error("comparator forced off in shallow mode");
    wdt_clock_a: assert property (periph.wdt_enabled |-> wdt_clk_en)
        else $error("enabled watchdog lost its clock");
    bod_back_a: assert property ($rose(core_run) |-> bod_enable && $past(bod_enable))
        else $error("detector not back on before code resumes");
    bod_sleep_a: assert property ($fell(bod_enable) |-> !core_run [*3])
        else $error("detector turned off outside sleep");

    cover property ($fell(core_run));
    cover property (adc_start);
    cover property ($fell(bod_enable));
    cover property (input_buf_off);
endmodule
bind smc_top smc_checker #(
    .STARTUP_CYCLES(STARTUP_CYCLES),
    .BOD_WAKE_CYCLES(BOD_WAKE_CYCLES)
) chk (.clk, .rstn, .sleep_instr, .periph, .clk_en, .periph_clk_en, .periph_access_en,
    .wdt_clk_en, .bod_enable, .adc_start, .adc_extended_next, .comparator_disable,
    .input_buf_off, .core_run);

// ==== test/smc_core_model.sv ====
// Purpose: core and peripheral side seen by the controller
// Assumes: bench requests a sleep opcode with go and picks pending wake sources
// Notes: purely combinational so the bench controls every cycle of timing
`timescale 1ns/1ps
module smc_core_model (
    input wire logic go,
    input wire logic core_run,
    input wire smc_pkg::smc_wake_t wake_pick,
    output logic sleep_instr,
    output smc_pkg::smc_wake_t wake_req
);
    import smc_pkg::*;
    // a halted core executes nothing, so no opcode while stopped
    assign sleep_instr = go && core_run;
    // pending requests are serviced once code runs again, so they drop then
    assign wake_req = core_run ? smc_wake_t'(9'h000) : wake_pick;
endmodule

// ==== test/smc_top_test.sv ====
// Purpose: self-checking bench for the sleep and clock gating controller
// Assumes: crystal selected after reset, short start-up counts for run time
// Notes: power-reduction values and peripheral settings come from a fixed-seed shift register
`timescale 1ns/1ps
module smc_top_test;
    import smc_pkg::*;
    localparam int SU = 8;
    localparam int BW = 10;
    logic clk, rstn, cyc, stb, we, ack, go, sleep_instr, core_run, bod_enable, adc_start;
    logic adc_ext, wdt_clk_en, cmp_dis, buf_off, t2, ten, tas;
    logic [7:0] adr, pclk, pacc, v;
    logic [31:0] dat_w, dat_r, rd;
    logic [15:0] lfsr_q;
    logic [2:0] k;
    smc_wake_t wake_pick, wake_req;
    smc_periph_t periph;
    smc_clk_t clk_en;
    int err_total, n_compared, n, i, d;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    logic [2:0] kk [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

    smc_top #(.STARTUP_CYCLES(SU), .BOD_WAKE_CYCLES(BW)) dut (
        .clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .sleep_instr,
        .wake_req, .periph, .clk_en, .periph_clk_en(pclk), .periph_access_en(pacc),
        .timer2_clk_en(t2), .wdt_clk_en, .bod_enable, .adc_start, .adc_extended_next(adc_ext),
        .comparator_disable(cmp_dis), .input_buf_off(buf_off), .core_run);
    smc_core_model core (.go, .core_run, .wake_pick, .sleep_instr, .wake_req);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] exp_top(logic [2:0] m);
        return m == 3'h0 ? 4'h3 : (m == 3'h1 ? 4'h1 : 4'h0);
    endfunction
    function automatic int exp_n(logic [2:0] m);
        return m < 3'h2 ? HALT_CYC : (m > 3'h5 ? STANDBY_WAKE_CYC : SU);
    endfunction
    function automatic logic exp_asy(logic [2:0] m, logic en, logic asy);
        return m == 3'h0 || (m == 3'h1 && asy) || (m == 3'h3 && en) || (m == 3'h7 && en && asy);
    endfunction

    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        give_verdict();
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [7:0] dv);
        int t;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h0, dv};
        t = 0;
        do begin
            @(posedge clk);
            #1;
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1) hang();
        @(posedge clk);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic do_sleep();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask
    task automatic wake(smc_wake_t src, int cyc_n);
        n = 0;
        @(posedge clk);
        wake_pick <= src;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (core_run !== 1'b1 && n < 2000);
        if (core_run !== 1'b1) hang();
        chk("wake cycles", n, cyc_n + 1);
        @(posedge clk);
        wake_pick <= '0;
    endtask

    initial begin
        rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat_w = 32'h0;
        go = 1'b0;
        wake_pick = '0;
        periph = 6'h23;
        lfsr_q = 16'h2D4F;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, ra[i], 8'h00);
            chk("reset value", rd, rv[i]);
        end
        for (i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v = lfsr_q[7:0];
            bus(1'b1, ADDR_POWER_RED, v);
            bus(1'b0, ADDR_POWER_RED, 8'h00);
            chk("reduction readback", rd, v & PRR_MASK);
            chk("access enables", pacc, (v & PRR_MASK) ^ 8'hFF);
            chk("timer 2 clock", t2, !v[PR_TIM2_BIT]);
            chk("active peripheral clocks", pclk & 8'hAF, ~v & 8'hAF);
        end
        for (i = 0; i < 3; i++) begin
            bus(1'b1, ADDR_SLEEP_CTRL, i == 0 ? 8'h00 : (i == 1 ? 8'h09 : 8'h0B));
            do_sleep();
            chk("sleep refused", core_run, 1'b1);
        end
        bus(1'b1, ADDR_CONFIG, 8'h05);
        foreach (kk[j]) begin
            k = kk[j];
            lfsr_q = lfsr_next(lfsr_q);
            ten = lfsr_q[1];
            tas = lfsr_q[2];
            bus(1'b1, ADDR_SLEEP_CTRL, {4'h0, k, 1'b1});
            periph.adc_enabled <= lfsr_q[0];
            periph.timer2_enabled <= ten;
            periph.timer2_async <= tas;
            do_sleep();
            chk("core halted", core_run, 1'b0);
            chk("cpu io adc clocks", clk_en[6:3], exp_top(k));
            chk("adc start", adc_start, k < 3'h2 && lfsr_q[0]);
            chk("input buffers off", buf_off, k > 3'h1);
            chk("comparator off", cmp_dis, k > 3'h1);
            chk("watchdog clock", wdt_clk_en, 1'b1);
            chk("periph clocks", pclk & 8'hAF, k ? 8'(k == 3'h1 && !v[0]) : ~v & 8'hAF);
            chk("main oscillator", clk_en.main_osc, k == 3'h3 ? ten && !tas : k != 3'h2);
            chk("timer oscillator", clk_en.timer_osc, tas && k != 3'h2 && k != 3'h6);
            chk("async clock", clk_en.asy, exp_asy(k, ten, tas));
            if (k != 3'h0) begin
                @(posedge clk);
                wake_pick <= k == 3'h1 ? 9'h001 : 9'h100;
                repeat (3) @(posedge clk);
                #1;
                chk("foreign wake ignored", core_run, 1'b0);
            end
            wake(9'h002, exp_n(k));
        end
        bus(1'b1, ADDR_CORE_CTRL, 8'h40);
        bus(1'b0, ADDR_CORE_CTRL, 8'h00);
        chk("lone detector write", rd, 8'h00);
        for (d = 0; d < 2; d++) begin
            bus(1'b1, ADDR_CONFIG, d ? 8'h07 : 8'h05);
            bus(1'b1, ADDR_SLEEP_CTRL, 8'h05);
            bus(1'b1, ADDR_CORE_CTRL, 8'h60);
            bus(1'b1, ADDR_CORE_CTRL, 8'h40);
            repeat (d ? 7 : 1) @(posedge clk);
            do_sleep();
            chk("detector in sleep", bod_enable, d);
            chk("debug keeps oscillator", clk_en.main_osc, d);
            wake(9'h002, d ? SU : BW);
            chk("detector after wake", bod_enable, 1'b1);
        end
        bus(1'b1, ADDR_SLEEP_CTRL, 8'h01);
        periph.adc_enabled <= 1'b1;
        do_sleep();
        @(posedge clk);
        #1;
        chk("extended cleared", adc_ext, 1'b0);
        wake(9'h002, HALT_CYC);
        periph.adc_enabled <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("extended conversion", adc_ext, 1'b1);
        give_verdict();
    end
endmodule
